/* File: isf_pkg.sv */
// Purpose: Shared constants for the I/O sample formatter
// Assumes: 20 MHz module clock, byte-wide record stream
// Notes: Offsets are byte addresses on the plain register port
package isf_pkg;
   localparam int ISF_LINES = 13;
   localparam int ISF_ACH = 4;
   localparam int ISF_REC_MAX = 14;
   // Register offsets
   localparam logic [7:0] ISF_OFS_CMD = 8'h00;
   localparam logic [7:0] ISF_OFS_FUNC_LO = 8'h04;
   localparam logic [7:0] ISF_OFS_FUNC_HI = 8'h08;
   localparam logic [7:0] ISF_OFS_PULL_EN = 8'h0C;
   localparam logic [7:0] ISF_OFS_PULL_DIR = 8'h10;
   localparam logic [7:0] ISF_OFS_PERIOD = 8'h14;
   localparam logic [7:0] ISF_OFS_OPTIONS = 8'h18;
   localparam logic [7:0] ISF_OFS_DEST = 8'h1C;
   localparam logic [7:0] ISF_OFS_MODE = 8'h20;
   localparam logic [7:0] ISF_OFS_WAKE_CNT = 8'h24;
   localparam logic [7:0] ISF_OFS_STATUS = 8'h28;
   localparam logic [7:0] ISF_OFS_ACTIVE = 8'h2C;
   // Field positions
   localparam int ISF_CMD_APPLY = 0;
   localparam int ISF_CMD_QLOCAL = 1;
   localparam int ISF_CMD_QREMOTE = 2;
   localparam int ISF_OPT_MGMT = 0;
   localparam int ISF_OPT_DEST = 3;
   localparam int ISF_MODE_AREF = 0;
   localparam int ISF_MODE_API = 1;
   localparam int ISF_ST_QERR = 0;
   localparam int ISF_ST_FERR = 1;
   localparam int ISF_ST_BUSY = 2;
   localparam int ISF_ST_PEN = 3;
   localparam int ISF_ST_DROP = 4;
   localparam int ISF_ACT_AMASK = 16;
   // Reset values
   localparam logic [31:0] ISF_RST_FUNC_LO = 32'h0000_0000;
   localparam logic [19:0] ISF_RST_FUNC_HI = 20'h0_0000;
   localparam logic [15:0] ISF_RST_PERIOD = 16'h0000;
   localparam logic [7:0] ISF_RST_OPTIONS = 8'h00;
   localparam logic [31:0] ISF_RST_DEST = 32'h0000_0000;
   localparam logic [1:0] ISF_RST_MODE = 2'h1;
   localparam logic [7:0] ISF_RST_WAKE_CNT = 8'h01;
   // Pin function codes
   localparam logic [3:0] ISF_FN_OFF = 4'h0;
   localparam logic [3:0] ISF_FN_PERIPH = 4'h1;
   localparam logic [3:0] ISF_FN_ANALOG = 4'h2;
   localparam logic [3:0] ISF_FN_DIN = 4'h3;
   localparam logic [3:0] ISF_FN_DOUT_LO = 4'h4;
   localparam logic [3:0] ISF_FN_DOUT_HI = 4'h5;
   localparam logic [3:0] ISF_FN_XCVR_LO = 4'h6;
   localparam logic [3:0] ISF_FN_XCVR_HI = 4'h7;
   // Record constants
   localparam logic [7:0] ISF_SAMPLE_SETS = 8'h01;
   localparam logic [7:0] ISF_CR = 8'h0D;
   localparam logic [9:0] ISF_ADC_FULL = 10'h3FF;
   // Timing
   localparam int ISF_CLK_NS = 50;
   localparam int ISF_MS_NS = 1000000;
   localparam int ISF_MS_CYCLES = ISF_MS_NS / ISF_CLK_NS;
   localparam logic [1:0] ISF_MIN_GAP_MS = 2'h3;
endpackage

/* File: isf_io_sample_formatter.sv */
// Purpose: I/O line configuration and sample record builder
// Assumes: ADC readings and transceiver state come from logic on this clock
// Notes: Records leave as a byte stream with valid/ready and routing flags
`timescale 1ns/1ps
`default_nettype none
module isf_io_sample_formatter
   import isf_pkg::*;
#(
   parameter int TICK_CYCLES = ISF_MS_CYCLES
)
(
   input wire logic clock,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata,
   input wire logic [12:0] pin_in,
   output logic [12:0] pin_out,
   output logic [12:0] pin_oe_n,
   output logic [12:0] pull_en,
   output logic [12:0] pull_up,
   output logic [12:0] periph_en,
   output logic [12:0] pwm_en,
   output logic [3:0] analog_en,
   output logic analog_reference_select,
   input wire logic xcvr_active,
   input wire logic awake,
   input wire logic [10:0] adc0,
   input wire logic [10:0] adc1,
   input wire logic [10:0] adc2,
   input wire logic [10:0] adc3,
   output logic rec_valid,
   output logic [7:0] rec_data,
   output logic rec_first,
   output logic rec_last,
   input wire logic rec_ready,
   output logic rec_text,
   output logic rec_to_local,
   output logic rec_to_requester,
   output logic rec_to_mgmt,
   output logic rec_to_dest,
   output logic [31:0] rec_dest_addr,
   output logic query_error
);

   typedef enum logic [0:0] {ISF_IDLE, ISF_SEND} isf_state_t;

   // Keep each nibble whose new code is legal, else keep the old one
   function automatic logic [31:0] isf_merge(input logic [31:0] old_v, input logic [31:0] new_v);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 8; i++)
      begin
         if (new_v[4*i+3] == 1'b0)
         begin
            r[4*i +: 4] = new_v[4*i +: 4];
         end
      end
      return r;
   endfunction

   function automatic logic isf_bad(input logic [31:0] v, input int n);
      logic b;
      b = 1'b0;
      for (int i = 0; i < 8; i++)
      begin
         if (i < n && v[4*i+3])
         begin
            b = 1'b1;
         end
      end
      return b;
   endfunction

   function automatic logic [7:0] isf_hex(input logic [3:0] n);
      return (n < 4'hA) ? {4'h3, n} : {4'h4, n - 4'h9};
   endfunction

   function automatic logic [9:0] isf_sat(input logic [10:0] raw, input logic half_ref);
      logic [11:0] s;
      s = half_ref ? {raw, 1'b0} : {1'b0, raw};
      return (s > {2'h0, ISF_ADC_FULL}) ? ISF_ADC_FULL : s[9:0];
   endfunction

   // Pending and applied configuration
   logic [31:0] func_lo_r;
   logic [19:0] func_hi_r;
   logic [51:0] act_func_r;
   logic [12:0] pen_r;
   logic [12:0] pdir_r;
   logic [12:0] act_pen_r;
   logic [12:0] act_pdir_r;
   logic [15:0] period_r;
   logic [15:0] act_period_r;
   logic [7:0] options_r;
   logic [31:0] dest_r;
   logic [1:0] mode_r;
   logic [7:0] wake_cnt_r;
   logic qerr_r;
   logic ferr_r;
   logic drop_r;
   logic [31:0] reg_rdata_r;

   wire cmd_wr = reg_write && reg_addr == ISF_OFS_CMD;
   wire apply = cmd_wr && reg_wdata[ISF_CMD_APPLY];
   wire q_local = cmd_wr && reg_wdata[ISF_CMD_QLOCAL];
   wire q_remote = cmd_wr && reg_wdata[ISF_CMD_QREMOTE];
   wire wr_lo = reg_write && reg_addr == ISF_OFS_FUNC_LO;
   wire wr_hi = reg_write && reg_addr == ISF_OFS_FUNC_HI;
   wire [31:0] hi_ext = {12'h000, func_hi_r};
   wire [31:0] hi_merged = isf_merge(hi_ext, {12'h000, reg_wdata[19:0]});
   wire fn_bad = (wr_lo && isf_bad(reg_wdata, 8)) || (wr_hi && isf_bad(reg_wdata, 5));
   wire period_change = apply && period_r != act_period_r;
   wire half_ref = mode_r[ISF_MODE_AREF] == 1'b0;

   // Per-line decode of the applied codes
   logic [12:0] is_din;
   logic [12:0] is_dout;
   logic [12:0] is_xcvr;
   logic [12:0] dout_val;
   logic [12:0] pull_ok;
   logic [12:0] is_periph;
   logic [12:0] is_code2;
   for (genvar n = 0; n < ISF_LINES; n++)
   begin : g_dec
      wire [3:0] code = act_func_r[4*n +: 4];
      assign is_din[n] = code == ISF_FN_DIN;
      assign is_dout[n] = code == ISF_FN_DOUT_LO || code == ISF_FN_DOUT_HI;
      assign is_xcvr[n] = code == ISF_FN_XCVR_LO || code == ISF_FN_XCVR_HI;
      assign is_periph[n] = code == ISF_FN_PERIPH;
      assign is_code2[n] = code == ISF_FN_ANALOG;
      assign dout_val[n] = code == ISF_FN_DOUT_HI ||
                           (code == ISF_FN_XCVR_HI && xcvr_active) ||
                           (code == ISF_FN_XCVR_LO && !xcvr_active);
      assign pull_ok[n] = code == ISF_FN_DIN || code == ISF_FN_PERIPH;
   end
   wire [12:0] dmask = is_din | is_dout;
   wire [3:0] amask = is_code2[3:0];
   wire any_active = (|dmask) || (|amask);

   // Pin inputs pass two flip-flops before use
   logic [12:0] pin_s1_r;
   logic [12:0] pin_s2_r;
   logic awk_s1_r;
   logic awk_s2_r;
   logic awk_prev_r;
   always_ff @(posedge clock)
   begin
      pin_s1_r <= pin_in;
      pin_s2_r <= pin_s1_r;
      awk_s1_r <= awake;
      awk_s2_r <= awk_s1_r;
      awk_prev_r <= rst ? 1'b0 : awk_s2_r;
   end
   wire wake_edge = awk_s2_r && !awk_prev_r;
   wire [12:0] dstate = (is_dout & pin_out) | (is_din & pin_s2_r);

   // Register writes
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         func_lo_r <= ISF_RST_FUNC_LO;
         func_hi_r <= ISF_RST_FUNC_HI;
         act_func_r <= {ISF_RST_FUNC_HI, ISF_RST_FUNC_LO};
         pen_r <= 13'h0000;
         pdir_r <= 13'h0000;
         act_pen_r <= 13'h0000;
         act_pdir_r <= 13'h0000;
         period_r <= ISF_RST_PERIOD;
         act_period_r <= ISF_RST_PERIOD;
         options_r <= ISF_RST_OPTIONS;
         dest_r <= ISF_RST_DEST;
         mode_r <= ISF_RST_MODE;
         wake_cnt_r <= ISF_RST_WAKE_CNT;
      end
      else
      begin
         if (wr_lo)
         begin
            func_lo_r <= isf_merge(func_lo_r, reg_wdata);
         end
         if (wr_hi)
         begin
            func_hi_r <= hi_merged[19:0];
         end
         if (apply)
         begin
            act_func_r <= {func_hi_r, func_lo_r};
            act_pen_r <= pen_r;
            act_pdir_r <= pdir_r;
            act_period_r <= period_r;
         end
         if (reg_write && reg_addr == ISF_OFS_PULL_EN)
         begin
            pen_r <= reg_wdata[12:0];
         end
         if (reg_write && reg_addr == ISF_OFS_PULL_DIR)
         begin
            pdir_r <= reg_wdata[12:0];
         end
         if (reg_write && reg_addr == ISF_OFS_PERIOD)
         begin
            period_r <= reg_wdata[15:0];
         end
         if (reg_write && reg_addr == ISF_OFS_OPTIONS)
         begin
            options_r <= reg_wdata[7:0];
         end
         if (reg_write && reg_addr == ISF_OFS_DEST)
         begin
            dest_r <= reg_wdata;
         end
         if (reg_write && reg_addr == ISF_OFS_MODE)
         begin
            mode_r <= reg_wdata[1:0];
         end
         if (reg_write && reg_addr == ISF_OFS_WAKE_CNT)
         begin
            wake_cnt_r <= reg_wdata[7:0];
         end
      end
   end

   // Pin drive from applied configuration; reference select follows mode_r directly
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         pin_out <= 13'h0000;
         pin_oe_n <= 13'h1FFF;
         pull_en <= 13'h0000;
         pull_up <= 13'h0000;
         periph_en <= 13'h0000;
         pwm_en <= 13'h0000;
         analog_en <= 4'h0;
         analog_reference_select <= ISF_RST_MODE[ISF_MODE_AREF];
      end
      else
      begin
         pin_out <= dout_val & (is_dout | is_xcvr);
         pin_oe_n <= ~(is_dout | is_xcvr);
         pull_en <= act_pen_r & pull_ok;
         pull_up <= act_pdir_r & act_pen_r & pull_ok;
         periph_en <= is_periph;
         pwm_en <= {is_code2[12:4], 4'h0};
         analog_en <= amask;
         analog_reference_select <= mode_r[ISF_MODE_AREF];
      end
   end

   // Record image built from live samples
   logic [7:0] img [0:ISF_REC_MAX-1];
   logic [ISF_REC_MAX-1:0] fend;
   logic [3:0] img_len;
   logic [9:0] an [0:3];
   assign an[0] = isf_sat(adc0, half_ref);
   assign an[1] = isf_sat(adc1, half_ref);
   assign an[2] = isf_sat(adc2, half_ref);
   assign an[3] = isf_sat(adc3, half_ref);
   always_comb
   begin
      logic [3:0] pos;
      pos = 4'h4;
      fend = '0;
      for (int i = 0; i < ISF_REC_MAX; i++)
      begin
         img[i] = 8'h00;
      end
      img[0] = ISF_SAMPLE_SETS;
      fend[0] = 1'b1;
      img[1] = {3'h0, dmask[12:8]};
      img[2] = dmask[7:0];
      fend[2] = 1'b1;
      img[3] = {4'h0, amask};
      fend[3] = 1'b1;
      if (|dmask)
      begin
         img[4] = {3'h0, dstate[12:8]};
         img[5] = dstate[7:0];
         fend[5] = 1'b1;
         pos = 4'h6;
      end
      for (int c = 0; c < ISF_ACH; c++)
      begin
         if (amask[c])
         begin
            img[pos] = {6'h00, an[c][9:8]};
            img[pos + 4'h1] = an[c][7:0];
            fend[pos + 4'h1] = 1'b1;
            pos = pos + 4'h2;
         end
      end
      img_len = pos;
   end

   // Millisecond tick and periodic timer
   logic [15:0] tick_r;
   logic [15:0] per_cnt_r;
   logic [1:0] gap_r;
   logic [7:0] wk_seen_r;
   logic wake_ok_r;
   logic qpend_r;
   logic qrem_r;
   logic wpend_r;
   isf_state_t state_r;
   wire ms_tick = tick_r == 16'(TICK_CYCLES - 1);
   wire per_on = act_period_r != 16'h0000 && any_active && awk_s2_r && wake_ok_r;
   wire per_due = per_on && ms_tick && per_cnt_r + 16'h1 >= act_period_r;
   wire idle = state_r == ISF_IDLE;
   wire wake_hit = wake_edge && (wk_seen_r + 8'h1 >= wake_cnt_r);
   wire q_any = q_local || q_remote || qpend_r;
   wire start_q = idle && q_any && any_active;
   wire start_w = idle && !q_any && wpend_r && any_active;
   wire per_ok = per_due && gap_r >= ISF_MIN_GAP_MS - 2'h1;
   wire start_p = idle && !q_any && !wpend_r && per_ok;
   wire start = start_q || start_w || start_p;

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         tick_r <= 16'h0000;
         per_cnt_r <= 16'h0000;
         gap_r <= ISF_MIN_GAP_MS;
         wk_seen_r <= 8'h00;
         wake_ok_r <= 1'b1;
         wpend_r <= 1'b0;
      end
      else
      begin
         tick_r <= ms_tick ? 16'h0000 : tick_r + 16'h1;
         if (period_change || wake_edge || per_due || !per_on)
         begin
            per_cnt_r <= 16'h0000;
         end
         else if (ms_tick)
         begin
            per_cnt_r <= per_cnt_r + 16'h1;
         end
         if (start_p)
         begin
            gap_r <= 2'h0;
         end
         else if (ms_tick && gap_r != ISF_MIN_GAP_MS)
         begin
            gap_r <= gap_r + 2'h1;
         end
         if (wake_edge)
         begin
            wk_seen_r <= wake_hit ? 8'h00 : wk_seen_r + 8'h1;
            wake_ok_r <= wake_hit;
         end
         if (wake_edge && wake_hit)
         begin
            wpend_r <= 1'b1;
         end
         else if (start_w || !any_active)
         begin
            wpend_r <= 1'b0;
         end
      end
   end

   // Emitter
   logic [7:0] buf_r [0:ISF_REC_MAX-1];
   logic [ISF_REC_MAX-1:0] fend_r;
   logic [3:0] len_r;
   logic [3:0] idx_r;
   logic [1:0] ph_r;
   logic done_r;
   wire take = !rec_valid || rec_ready;
   wire last_idx = idx_r == len_r - 4'h1;
   wire [7:0] cur = buf_r[idx_r];
   wire [7:0] out_byte = !rec_text ? cur :
                         ph_r == 2'h0 ? isf_hex(cur[7:4]) :
                         ph_r == 2'h1 ? isf_hex(cur[3:0]) : ISF_CR;
   wire out_last = last_idx && (!rec_text || ph_r == 2'h2);
   wire text_cr = ph_r == 2'h1 && fend_r[idx_r];

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         state_r <= ISF_IDLE;
         rec_valid <= 1'b0;
         rec_data <= 8'h00;
         rec_first <= 1'b0;
         rec_last <= 1'b0;
         rec_text <= 1'b0;
         rec_to_local <= 1'b0;
         rec_to_requester <= 1'b0;
         rec_to_mgmt <= 1'b0;
         rec_to_dest <= 1'b0;
         rec_dest_addr <= ISF_RST_DEST;
         idx_r <= 4'h0;
         ph_r <= 2'h0;
         done_r <= 1'b0;
         len_r <= 4'h0;
         fend_r <= '0;
      end
      else if (start)
      begin
         state_r <= ISF_SEND;
         for (int i = 0; i < ISF_REC_MAX; i++)
         begin
            buf_r[i] <= img[i];
         end
         fend_r <= fend;
         len_r <= img_len;
         idx_r <= 4'h0;
         ph_r <= 2'h0;
         done_r <= 1'b0;
         rec_first <= 1'b1;
         rec_text <= start_q && !mode_r[ISF_MODE_API];
         rec_to_local <= start_q && !(qrem_r && qpend_r) && !q_remote;
         rec_to_requester <= start_q && (q_remote || (qpend_r && qrem_r));
         rec_to_mgmt <= !start_q && options_r[ISF_OPT_MGMT];
         rec_to_dest <= !start_q && (!options_r[ISF_OPT_MGMT] ||
                                     options_r[ISF_OPT_DEST]);
         rec_dest_addr <= dest_r;
      end
      else if (state_r == ISF_SEND && take)
      begin
         if (done_r)
         begin
            rec_valid <= 1'b0;
            rec_last <= 1'b0;
            state_r <= ISF_IDLE;
         end
         else
         begin
            rec_valid <= 1'b1;
            rec_data <= out_byte;
            rec_last <= out_last;
            rec_first <= idx_r == 4'h0 && ph_r == 2'h0;
            done_r <= out_last;
            if (!rec_text || ph_r == 2'h2 || (ph_r == 2'h1 && !text_cr))
            begin
               idx_r <= idx_r + 4'h1;
               ph_r <= 2'h0;
            end
            else
            begin
               ph_r <= text_cr ? 2'h2 : 2'h1;
            end
         end
      end
   end

   wire [31:0] status_w = {27'h0, drop_r, per_on, !idle, ferr_r, qerr_r};
   wire [31:0] rd_mux = !reg_read ? 32'h0 :
      reg_addr == ISF_OFS_FUNC_LO ? func_lo_r :
      reg_addr == ISF_OFS_FUNC_HI ? hi_ext :
      reg_addr == ISF_OFS_PULL_EN ? {19'h0, pen_r} :
      reg_addr == ISF_OFS_PULL_DIR ? {19'h0, pdir_r} :
      reg_addr == ISF_OFS_PERIOD ? {16'h0, period_r} :
      reg_addr == ISF_OFS_OPTIONS ? {24'h0, options_r} :
      reg_addr == ISF_OFS_DEST ? dest_r :
      reg_addr == ISF_OFS_MODE ? {30'h0, mode_r} :
      reg_addr == ISF_OFS_WAKE_CNT ? {24'h0, wake_cnt_r} :
      reg_addr == ISF_OFS_STATUS ? status_w :
      reg_addr == ISF_OFS_ACTIVE ? {12'h0, amask, 3'h0, dmask} : 32'h0;

   // Query holding, status and read port
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         qpend_r <= 1'b0;
         qrem_r <= 1'b0;
         qerr_r <= 1'b0;
         ferr_r <= 1'b0;
         drop_r <= 1'b0;
         query_error <= 1'b0;
         reg_rdata_r <= 32'h0000_0000;
      end
      else
      begin
         if ((q_local || q_remote) && !start_q && any_active)
         begin
            qpend_r <= 1'b1;
            qrem_r <= q_remote;
         end
         else if (start_q)
         begin
            qpend_r <= 1'b0;
         end
         query_error <= q_any && !any_active;
         if (q_any && !any_active)
         begin
            qpend_r <= 1'b0;
         end
         // Hardware set wins over a software clear in the same cycle
         qerr_r <= (q_any && !any_active) ||
                   (qerr_r && !(reg_write && reg_addr == ISF_OFS_STATUS &&
                                reg_wdata[ISF_ST_QERR]));
         ferr_r <= fn_bad || (ferr_r && !(reg_write && reg_addr == ISF_OFS_STATUS &&
                                          reg_wdata[ISF_ST_FERR]));
         drop_r <= (per_due && !start_p) ||
                   (drop_r && !(reg_write && reg_addr == ISF_OFS_STATUS &&
                                reg_wdata[ISF_ST_DROP]));
         reg_rdata_r <= rd_mux;
      end
   end

   assign reg_rdata = reg_rdata_r;

endmodule // isf_io_sample_formatter
`default_nettype wire

/* File: isf_props.sv */
// Purpose: Port assertions for the sample formatter
// Assumes: One clock, synchronous reset
// Notes: Bound to every formatter instance
`timescale 1ns/1ps
`default_nettype none
module isf_props
   import isf_pkg::*;
#(
   parameter int TICK_CYCLES = ISF_MS_CYCLES
)
(
   input wire logic clock,
   input wire logic rst,
   input wire logic reg_read,
   input wire logic [31:0] reg_rdata,
   input wire logic [12:0] pin_oe_n,
   input wire logic [12:0] pull_en,
   input wire logic [3:0] analog_en,
   input wire logic rec_valid,
   input wire logic [7:0] rec_data,
   input wire logic rec_first,
   input wire logic rec_last,
   input wire logic rec_ready,
   input wire logic rec_text,
   input wire logic rec_to_local,
   input wire logic rec_to_requester,
   input wire logic rec_to_mgmt,
   input wire logic rec_to_dest,
   input wire logic query_error
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   logic [3:0] idx_r;
   logic [3:0] idx_nxt;
   wire logic taken;
   wire logic raw;
   assign taken = rec_valid && rec_ready;
   assign raw = rec_valid && !rec_text;
   // Byte position inside the current record
   assign idx_nxt = !taken ? idx_r : (rec_last ? 4'h0 : idx_r + 4'h1);
   always_ff @(posedge clock)
   begin
      if (rst)
         idx_r <= 4'h0;
      else
         idx_r <= idx_nxt;
   end
   sequence s_last_taken;
      taken && rec_last;
   endsequence
   sequence s_gap_or_next;
      !rec_valid || rec_first;
   endsequence
   a_count_byte:
      assert property (raw && idx_r == 4'h0 |-> rec_first && rec_data == ISF_SAMPLE_SETS)
      else $error("bad count byte");
   a_dmask_width:
      assert property (raw && idx_r == 4'h1 |-> rec_data[7:5] == 3'h0)
      else $error("digital mask too wide");
   a_amask_width:
      assert property (raw && idx_r == 4'h3 |-> rec_data[7:4] == 4'h0)
      else $error("analog mask too wide");
   a_hold_byte:
      assert property (rec_valid && !rec_ready |=> rec_valid && $stable(rec_data) && $stable(rec_last))
      else $error("byte not held");
   a_record_apart:
      assert property (s_last_taken |=> s_gap_or_next)
      else $error("records overlap");
   a_pull_gated:
      assert property (((pull_en & ~pin_oe_n) == 13'h0000) && ((pull_en[3:0] & analog_en) == 4'h0))
      else $error("pull on output or analog line");
   a_rdata_idle:
      assert property (!reg_read |=> reg_rdata == 32'h0000_0000)
      else $error("read data outside slot");
   a_err_pulse:
      assert property (query_error |=> !query_error)
      else $error("query error too long");
   a_query_route:
      assert property (rec_valid && (rec_to_local || rec_to_requester) |-> !rec_to_mgmt && !rec_to_dest && !(rec_to_local && rec_to_requester))
      else $error("query routing mixed");
   a_text_first:
      assert property (rec_valid && rec_text && idx_r == 4'h0 |-> rec_data == 8'h30)
      else $error("text record start");
endmodule // isf_props
bind isf_io_sample_formatter isf_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (
   .clock(clock), .rst(rst), .reg_read(reg_read), .reg_rdata(reg_rdata),
   .pin_oe_n(pin_oe_n), .pull_en(pull_en), .analog_en(analog_en), .rec_valid(rec_valid),
   .rec_data(rec_data), .rec_first(rec_first), .rec_last(rec_last), .rec_ready(rec_ready),
   .rec_text(rec_text), .rec_to_local(rec_to_local), .rec_to_requester(rec_to_requester),
   .rec_to_mgmt(rec_to_mgmt), .rec_to_dest(rec_to_dest), .query_error(query_error));
`default_nettype wire

/* File: isf_rec_sink.sv */
// Purpose: Record stream sink standing in for the host port
// Assumes: Bytes taken when valid and ready meet at an edge
// Notes: Stall halves the accept rate by toggling ready
`timescale 1ns/1ps
`default_nettype none
module isf_rec_sink
(
   input wire logic clock,
   input wire logic rst,
   input wire logic rec_valid,
   input wire logic [7:0] rec_data,
   input wire logic rec_first,
   input wire logic rec_last,
   input wire logic stall,
   output logic rec_ready
);
   logic [7:0] rec_bytes [0:31];
   int n_rec;
   int n_byte;
   always @(posedge clock)
   begin
      if (rst)
      begin
         n_rec <= 0;
         n_byte <= 0;
         rec_ready <= 1'b0;
      end
      else
      begin
         rec_ready <= stall ? !rec_ready : 1'b1;
         if (rec_valid && rec_ready)
         begin
            rec_bytes[rec_first ? 5'd0 : n_byte[4:0]] <= rec_data;
            n_byte <= rec_first ? 1 : n_byte + 1;
            if (rec_last)
               n_rec <= n_rec + 1;
         end
      end
   end
endmodule // isf_rec_sink
`default_nettype wire

/* File: tb_isf_io_sample_formatter.sv */
// Purpose: Self-checking bench for the sample formatter
// Assumes: TICK_CYCLES of 20 makes one ms 20 cycles
// Notes: Record bytes are read back from the sink model
`timescale 1ns/1ps
`default_nettype none
module tb_isf_io_sample_formatter import isf_pkg::*;;
   logic clock, rst, reg_write, reg_read, xcvr_active, awake, stall, rec_ready;
   logic [7:0] reg_addr, rec_data;
   logic [31:0] reg_wdata, reg_rdata;
   logic [12:0] pin_in, pin_out, pin_oe_n, pull_en, pull_up;
   logic [3:0] analog_en;
   logic ref_sel, rec_valid, rec_first, rec_last, rec_text;
   logic to_loc, to_req, to_mgmt, to_dest, query_error;
   logic [10:0] adc0, adc1, adc2, adc3;
   logic [7:0] exp [0:9];
   int errors, n_checks, cyc, nr, n0;
   isf_io_sample_formatter #(.TICK_CYCLES(20)) dut (.clock(clock), .rst(rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
      .reg_read(reg_read), .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out),
      .pin_oe_n(pin_oe_n), .pull_en(pull_en), .pull_up(pull_up), .periph_en(), .pwm_en(),
      .analog_en(analog_en), .analog_reference_select(ref_sel), .xcvr_active(xcvr_active),
      .awake(awake), .adc0(adc0), .adc1(adc1), .adc2(adc2), .adc3(adc3),
      .rec_valid(rec_valid), .rec_data(rec_data), .rec_first(rec_first),
      .rec_last(rec_last), .rec_ready(rec_ready), .rec_text(rec_text),
      .rec_to_local(to_loc), .rec_to_requester(to_req), .rec_to_mgmt(to_mgmt),
      .rec_to_dest(to_dest), .rec_dest_addr(), .query_error(query_error));
   isf_rec_sink u_sink (.clock(clock), .rst(rst), .rec_valid(rec_valid),
      .rec_data(rec_data), .rec_first(rec_first), .rec_last(rec_last), .stall(stall),
      .rec_ready(rec_ready));
   task automatic chk(input logic [31:0] seen, input logic [31:0] want);
      n_checks++;
      if (seen !== want)
      begin
         errors++;
         $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, want);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] want);
      @(posedge clock);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      #1;
      chk(reg_rdata, want);
   endtask
   task automatic query(input logic [31:0] cmd);
      wr(ISF_OFS_CMD, cmd);
      nr++;
      for (int k = 0; k < 2000 && u_sink.n_rec < nr; k++)
         @(posedge clock);
      #1;
      chk(u_sink.n_rec, nr);
   endtask
   task automatic chk_rec(input int n);
      for (int i = 0; i < n; i++)
         chk(u_sink.rec_bytes[i], exp[i]);
   endtask
   task automatic complete_run;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial
   begin
      clock = 1'b0;
      forever #25 clock = !clock;
   end
   always @(posedge clock)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         errors++;
         complete_run();
      end
   end
   initial
   begin
      {rst, awake} = 2'h3;
      {reg_write, reg_read, xcvr_active, stall} = 4'h0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      pin_in = 13'h0000;
      {adc0, adc1, adc2, adc3} = 44'h0;
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      #1;
      chk(ref_sel, 1'b1);
      rd(ISF_OFS_MODE, 32'h1);
      rd(8'h30, 32'h0);
      wr(ISF_OFS_CMD, 32'h2);
      rd(ISF_OFS_STATUS, 32'h1);
      wr(ISF_OFS_STATUS, 32'h1);
      $display("test reset and empty query done");
      wr(ISF_OFS_FUNC_LO, 32'h0005_3228);
      wr(ISF_OFS_PULL_EN, 32'h1FFF);
      wr(ISF_OFS_PULL_DIR, 32'h8);
      #1;
      chk(pull_en, 13'h0000);
      chk(pin_oe_n, 13'h1FFF);
      rd(ISF_OFS_STATUS, 32'h2);
      wr(ISF_OFS_CMD, 32'h1);
      repeat (2) @(posedge clock);
      #1;
      chk(pull_en, 13'h0008);
      chk(pull_up & pull_en, 13'h0008);
      chk(pin_oe_n, 13'h1FEF);
      chk(pin_out[4], 1'b1);
      chk(analog_en, 4'h6);
      rd(ISF_OFS_ACTIVE, 32'h0006_0018);
      $display("test config done");
      pin_in <= 13'h0018;
      wr(ISF_OFS_MODE, 32'h3);
      adc1 <= 11'h7FF;
      adc2 <= 11'h124;
      stall <= 1'b1;
      exp = '{8'h01, 8'h00, 8'h18, 8'h06, 8'h00, 8'h18, 8'h03, 8'hFF, 8'h01, 8'h24};
      query(32'h2);
      chk_rec(10);
      chk({to_loc, rec_text}, 2'h2);
      query(32'h4);
      chk({to_req, to_loc}, 2'h2);
      wr(ISF_OFS_MODE, 32'h2);
      exp[8] = 8'h02;
      exp[9] = 8'h48;
      query(32'h2);
      chk(ref_sel, 1'b0);
      chk_rec(10);
      wr(ISF_OFS_MODE, 32'h0);
      exp[0] = 8'h30;
      exp[1] = 8'h31;
      exp[2] = 8'h0D;
      query(32'h2);
      chk(rec_text, 1'b1);
      chk_rec(3);
      $display("test queries done");
      stall <= 1'b0;
      wr(ISF_OFS_OPTIONS, 32'h9);
      wr(ISF_OFS_PERIOD, 32'h1);
      wr(ISF_OFS_CMD, 32'h1);
      n0 = u_sink.n_rec;
      repeat (600) @(posedge clock);
      #1;
      chk((u_sink.n_rec - n0) inside {[8:10]}, 1'b1);
      chk({to_mgmt, to_dest, rec_text}, 3'h6);
      wr(ISF_OFS_OPTIONS, 32'h0);
      repeat (200) @(posedge clock);
      #1;
      chk({to_mgmt, to_dest}, 2'h1);
      wr(ISF_OFS_PERIOD, 32'h0);
      wr(ISF_OFS_CMD, 32'h1);
      repeat (100) @(posedge clock);
      n0 = u_sink.n_rec;
      repeat (200) @(posedge clock);
      chk(u_sink.n_rec, n0);
      $display("test periodic done");
      complete_run();
   end
endmodule // tb_isf_io_sample_formatter
`default_nettype wire
